/* File: dac_link_pkg.sv */
// shared constants for the dual converter input link
package dac_link_pkg;

  localparam int DATA_WIDTH = 14;
  localparam int CHANNELS = 2;
  localparam int LATENCY_UPDATES = 4;

  // segmented decoder: upper bits thermometer, lower bits binary
  localparam int SEG_BITS = 4;
  localparam int LSB_BITS = 10;
  localparam int THERMO_WIDTH = 15;
  localparam int SWITCH_WIDTH = THERMO_WIDTH + LSB_BITS;

  // positions inside the synchronised pin vector
  localparam int PIN_DATA_FIRST = 0;
  localparam int PIN_DATA_SECOND = DATA_WIDTH;
  localparam int PIN_WRITE = 2 * DATA_WIDTH;
  localparam int PIN_UPDATE = 2 * DATA_WIDTH + 2;
  localparam int PIN_SELECT = 2 * DATA_WIDTH + 4;
  localparam int PIN_PAIR = 2 * DATA_WIDTH + 5;
  localparam int PIN_MODE = 2 * DATA_WIDTH + 6;
  localparam int PIN_WIDTH = 2 * DATA_WIDTH + 7;

  // reset values
  localparam logic [DATA_WIDTH-1:0] CODE_RESET = 14'h0000;
  localparam logic [SWITCH_WIDTH-1:0] SWITCH_RESET = '0;
  localparam logic STRAP_RESET = 1'b1;
  // one more edge: the source's strap flop leaves reset one edge late
  localparam logic [1:0] STRAP_WAIT_CYCLES = 2'h3;

  // host timing, in system clock cycles (20 MHz)
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int CLK_AFTER_WRITE_NS = 2;
  localparam int CLK_AFTER_WRITE_CYCLES =
    (CLK_AFTER_WRITE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [1:0] STROBE_HALF_LAST = 2'h1;
  localparam logic [3:0] PAIR_RESET_LAST = 4'h7;

  typedef enum logic [0:0] {HOST_PAIR, HOST_RUN} host_state_type;

endpackage : dac_link_pkg

/* File: dac_link_if.sv */
// pin bundle between data source and converter input front end
`timescale 1ns/100ps
interface dac_link_if;
  logic [dac_link_pkg::DATA_WIDTH-1:0] data_first;
  logic [dac_link_pkg::DATA_WIDTH-1:0] data_second;
  logic write_strobe_first;
  logic write_strobe_second;
  logic update_clock_first;
  logic update_clock_second;
  logic channel_select;
  logic pairing_reset;
  logic mode_strap;

  modport device (
    input data_first,
    input data_second,
    input write_strobe_first,
    input write_strobe_second,
    input update_clock_first,
    input update_clock_second,
    input channel_select,
    input pairing_reset,
    input mode_strap
  );

  modport host (
    output data_first,
    output data_second,
    output write_strobe_first,
    output write_strobe_second,
    output update_clock_first,
    output update_clock_second,
    output channel_select,
    output pairing_reset,
    output mode_strap
  );
endinterface : dac_link_if

/* File: dac_input_host.sv */
// data source end: drives strobes, clocks, words and pairing reset
`timescale 1ns/100ps
module dac_input_host (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_mode_dual,
  input wire logic i_sample_valid,
  input wire logic [dac_link_pkg::DATA_WIDTH-1:0] i_sample_first,
  input wire logic [dac_link_pkg::DATA_WIDTH-1:0] i_sample_second,
  input wire logic i_pair_request,
  output logic o_sample_taken,
  output logic o_pairing,
  dac_link_if.host link
);

  logic [1:0] half_cnt;
  logic strobe;
  logic going_low;
  logic mode_dual;
  logic [3:0] pair_cnt;
  logic pairing;
  logic release_pair;
  logic word_phase;
  logic select;
  logic taken;
  logic [dac_link_pkg::DATA_WIDTH-1:0] word_first;
  logic [dac_link_pkg::DATA_WIDTH-1:0] word_second;
  logic [dac_link_pkg::DATA_WIDTH-1:0] hold_first;
  logic [dac_link_pkg::DATA_WIDTH-1:0] hold_second;
  dac_link_pkg::host_state_type state;

  // one divider makes strobe and clock: same period, same phase
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_cnt <= '0;
      strobe <= 1'b0;
    end else if (half_cnt == dac_link_pkg::STROBE_HALF_LAST) begin
      half_cnt <= '0;
      strobe <= ~strobe;
    end else begin
      half_cnt <= half_cnt + 2'h1;
    end
  end

  assign going_low = strobe && (half_cnt == dac_link_pkg::STROBE_HALF_LAST);
  assign release_pair = going_low && !word_phase &&
                        (pair_cnt == dac_link_pkg::PAIR_RESET_LAST);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_dual <= dac_link_pkg::STRAP_RESET;
    end else begin
      mode_dual <= i_mode_dual;
    end
  end

  // pairing reset: held, then dropped just before a first-channel word
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= dac_link_pkg::HOST_PAIR;
      pair_cnt <= '0;
      pairing <= 1'b1;
    end else begin
      case (state)
        dac_link_pkg::HOST_PAIR: begin
          if (pair_cnt != dac_link_pkg::PAIR_RESET_LAST) begin
            pair_cnt <= pair_cnt + 4'h1;
          end else if (release_pair) begin
            state <= dac_link_pkg::HOST_RUN;
            pairing <= 1'b0;
          end
        end
        dac_link_pkg::HOST_RUN: begin
          if (i_pair_request) begin
            state <= dac_link_pkg::HOST_PAIR;
            pair_cnt <= '0;
            pairing <= 1'b1;
          end
        end
        default: begin
          state <= dac_link_pkg::HOST_PAIR;
          pair_cnt <= '0;
          pairing <= 1'b1;
        end
      endcase
    end
  end

  // words change on the strobe's falling side, stable at its rise
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_first <= dac_link_pkg::CODE_RESET;
      word_second <= dac_link_pkg::CODE_RESET;
      hold_first <= dac_link_pkg::CODE_RESET;
      hold_second <= dac_link_pkg::CODE_RESET;
      select <= 1'b1;
      word_phase <= 1'b0;
      taken <= 1'b0;
    end else begin
      taken <= 1'b0;
      if (going_low && mode_dual) begin
        select <= 1'b1;
        word_phase <= 1'b0;
        if (i_sample_valid) begin
          word_first <= i_sample_first;
          word_second <= i_sample_second;
          taken <= 1'b1;
        end
      end else if (going_low && !word_phase) begin
        select <= 1'b1;
        word_phase <= 1'b1;
        if (i_sample_valid) begin
          word_first <= i_sample_first;
          hold_first <= i_sample_first;
          hold_second <= i_sample_second;
          taken <= 1'b1;
        end else begin
          word_first <= hold_first;
        end
      end else if (going_low) begin
        select <= 1'b0;
        word_phase <= 1'b0;
        word_first <= hold_second;
      end
    end
  end

  assign o_sample_taken = taken;
  assign o_pairing = pairing;
  assign link.data_first = word_first;
  assign link.data_second = word_second;
  assign link.write_strobe_first = strobe;
  assign link.write_strobe_second = strobe;
  // clocks tied to strobes: clock never trails write
  assign link.update_clock_first = strobe;
  assign link.update_clock_second = strobe;
  assign link.channel_select = select;
  assign link.pairing_reset = pairing;
  assign link.mode_strap = mode_dual;

endmodule : dac_input_host

/* File: dac_input_device.sv */
// converter end: input latches, converter latches and switch decoder
`timescale 1ns/100ps
module dac_input_device (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  dac_link_if.device link,
  output logic [dac_link_pkg::DATA_WIDTH-1:0] o_code_first,
  output logic [dac_link_pkg::DATA_WIDTH-1:0] o_code_second,
  output logic [dac_link_pkg::SWITCH_WIDTH-1:0] o_switch_first,
  output logic [dac_link_pkg::SWITCH_WIDTH-1:0] o_switch_second,
  output logic o_update_first,
  output logic o_update_second,
  output logic o_divided_converter_clock,
  output logic o_mode_dual
);

  localparam int DW = dac_link_pkg::DATA_WIDTH;
  localparam int NCH = dac_link_pkg::CHANNELS;
  localparam int LAT = dac_link_pkg::LATENCY_UPDATES;
  localparam int SWW = dac_link_pkg::SWITCH_WIDTH;

  // thermometer code for the upper segment bits
  function automatic logic [dac_link_pkg::THERMO_WIDTH-1:0] thermo_decode(
    input logic [dac_link_pkg::SEG_BITS-1:0] seg
  );
    logic [dac_link_pkg::THERMO_WIDTH-1:0] t;
    t = '0;
    for (int i = 0; i < dac_link_pkg::THERMO_WIDTH; i++) begin
      t[i] = (int'(seg) > i);
    end
    return t;
  endfunction : thermo_decode

  // full switch word: thermometer segments above binary weighted bits
  function automatic logic [SWW-1:0] switch_decode(
    input logic [DW-1:0] code
  );
    return {thermo_decode(code[DW-1:dac_link_pkg::LSB_BITS]),
            code[dac_link_pkg::LSB_BITS-1:0]};
  endfunction : switch_decode

  logic [dac_link_pkg::PIN_WIDTH-1:0] pin_raw;
  logic [dac_link_pkg::PIN_WIDTH-1:0] pin_meta;
  logic [dac_link_pkg::PIN_WIDTH-1:0] pin_sync;
  logic [dac_link_pkg::PIN_WIDTH-1:0] pin_prev;
  logic [NCH-1:0] wr_rise;
  logic [NCH-1:0] up_rise;
  logic [DW-1:0] data_in [NCH];
  logic select_in;
  logic pair_in;
  logic [1:0] strap_wait;
  logic strap_taken;
  logic mode_dual;
  logic div_clk;
  logic div_rise;
  logic [NCH-1:0] upd;
  logic [NCH-1:0] upd_q;
  logic [DW-1:0] in_latch [NCH];
  logic [DW-1:0] stage [NCH][LAT];
  logic [SWW-1:0] switch_q [NCH];

  assign pin_raw = {link.mode_strap,
                    link.pairing_reset,
                    link.channel_select,
                    link.update_clock_second,
                    link.update_clock_first,
                    link.write_strobe_second,
                    link.write_strobe_first,
                    link.data_second,
                    link.data_first};

  // every pin passes two flops; edges are taken from the second
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign data_in[0] = pin_sync[dac_link_pkg::PIN_DATA_FIRST +: DW];
  assign data_in[1] = pin_sync[dac_link_pkg::PIN_DATA_SECOND +: DW];
  assign select_in = pin_sync[dac_link_pkg::PIN_SELECT];
  assign pair_in = pin_sync[dac_link_pkg::PIN_PAIR];

  for (genvar g = 0; g < NCH; g++) begin : g_edge
    assign wr_rise[g] = pin_sync[dac_link_pkg::PIN_WRITE + g] &
                        ~pin_prev[dac_link_pkg::PIN_WRITE + g];
    assign up_rise[g] = pin_sync[dac_link_pkg::PIN_UPDATE + g] &
                        ~pin_prev[dac_link_pkg::PIN_UPDATE + g];
  end

  // strap is sampled once, after the synchroniser has filled
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_wait <= '0;
      strap_taken <= 1'b0;
      mode_dual <= dac_link_pkg::STRAP_RESET;
    end else if (!strap_taken) begin
      if (strap_wait == dac_link_pkg::STRAP_WAIT_CYCLES) begin
        mode_dual <= pin_sync[dac_link_pkg::PIN_MODE];
        strap_taken <= 1'b1;
      end else begin
        strap_wait <= strap_wait + 2'h1;
      end
    end
  end

  // input latches
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        in_latch[ch] <= dac_link_pkg::CODE_RESET;
      end
    end else if (strap_taken && mode_dual) begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (wr_rise[ch]) begin
          in_latch[ch] <= data_in[ch];
        end
      end
    end else if (strap_taken && wr_rise[0]) begin
      // shared strobe; second bus and second strobe are not looked at
      if (select_in) begin
        in_latch[0] <= data_in[0];
      end else begin
        in_latch[1] <= data_in[0];
      end
    end
  end

  // divided converter clock for interleaved mode
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_clk <= 1'b0;
    end else if (mode_dual || !strap_taken || pair_in) begin
      div_clk <= 1'b0;
    end else if (up_rise[0]) begin
      div_clk <= ~div_clk;
    end
  end

  assign div_rise = up_rise[0] & ~div_clk & ~pair_in & ~mode_dual &
                    strap_taken;

  for (genvar g = 0; g < NCH; g++) begin : g_upd
    assign upd[g] = strap_taken & (mode_dual ? up_rise[g] : div_rise);
  end

  // converter latch plus delay stages: four updates from write to code
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        for (int k = 0; k < LAT; k++) begin
          stage[ch][k] <= dac_link_pkg::CODE_RESET;
        end
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (upd[ch]) begin
          stage[ch][0] <= in_latch[ch];
          for (int k = 1; k < LAT; k++) begin
            stage[ch][k] <= stage[ch][k-1];
          end
        end
      end
    end
  end

  // current switch settings, refreshed with the output code
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int ch = 0; ch < NCH; ch++) begin
        switch_q[ch] <= dac_link_pkg::SWITCH_RESET;
      end
    end else begin
      for (int ch = 0; ch < NCH; ch++) begin
        if (upd[ch]) begin
          switch_q[ch] <= switch_decode(stage[ch][LAT-2]);
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      upd_q <= '0;
    end else begin
      upd_q <= upd;
    end
  end

  assign o_code_first = stage[0][LAT-1];
  assign o_code_second = stage[1][LAT-1];
  assign o_switch_first = switch_q[0];
  assign o_switch_second = switch_q[1];
  assign o_update_first = upd_q[0];
  assign o_update_second = upd_q[1];
  assign o_divided_converter_clock = div_clk;
  assign o_mode_dual = mode_dual;

endmodule : dac_input_device

/* File: dac_link_asserts.sv */
// concurrent checks on the pin bundle between data source and converter
`timescale 1ns/100ps
module dac_link_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [dac_link_pkg::DATA_WIDTH-1:0] data_first,
  input wire logic write_strobe_first,
  input wire logic write_strobe_second,
  input wire logic update_clock_first,
  input wire logic update_clock_second,
  input wire logic channel_select,
  input wire logic pairing_reset,
  input wire logic mode_strap
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_clock_first_early: assert property (
    $rose(write_strobe_first) |-> $rose(update_clock_first))
    else $error("first update clock rose after its write strobe");
  a_clock_second_early: assert property (
    $rose(write_strobe_second) |-> $rose(update_clock_second))
    else $error("second update clock rose after its write strobe");
  a_period_first_four: assert property (
    $rose(write_strobe_first) |-> write_strobe_first[*2]
    ##1 !write_strobe_first[*2] ##1 write_strobe_first)
    else $error("first write strobe period is not four cycles");
  a_period_second_four: assert property (
    $rose(write_strobe_second) |-> write_strobe_second[*2]
    ##1 !write_strobe_second[*2] ##1 write_strobe_second)
    else $error("second write strobe period is not four cycles");
  a_select_alternates: assert property (
    !mode_strap && !pairing_reset && $rose(write_strobe_first)
    ##4 !pairing_reset |-> channel_select != $past(channel_select, 4))
    else $error("interleaved words do not alternate channels");
  a_data_held_rise: assert property (
    $rose(write_strobe_first) |-> $stable(data_first)
    ##1 $stable(data_first))
    else $error("data moved around the write strobe rise");
  a_pair_hold_eight: assert property (
    $rose(pairing_reset) |-> pairing_reset[*8])
    else $error("pairing reset held under eight cycles");
  a_pair_release_first: assert property (
    $fell(pairing_reset) && !mode_strap |-> channel_select)
    else $error("pairing reset released without a first word");
endmodule : dac_link_asserts

/* File: tb_dual_dac_input_interface.sv */
// self-checking bench: data source and converter end on one pin bundle
`timescale 1ns/100ps
module tb_dual_dac_input_interface;
  localparam int DW = dac_link_pkg::DATA_WIDTH;
  localparam int SW = dac_link_pkg::SWITCH_WIDTH;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic mode_dual = 1'b1;
  logic valid = 1'b0;
  logic pair_req = 1'b0;
  logic [DW-1:0] sf = 14'h0000;
  logic [DW-1:0] ss = 14'h0000;
  logic taken, pairing, upd_a, upd_b, div_clk, mode_seen;
  logic [DW-1:0] code_a, code_b;
  logic [SW-1:0] sw_a, sw_b;
  logic [DW-1:0] ua[$], ub[$], wa[$], wb[$];
  int pa[$], pb[$];
  logic [3:0] pr = 4'h0;
  logic wa_prev = 1'b0;
  logic wb_prev = 1'b0;
  int n_mismatch = 0;
  int tests_run = 0;

  dac_link_if link ();
  dac_input_host u_dac_input_host (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_mode_dual(mode_dual), .i_sample_valid(valid), .i_sample_first(sf),
    .i_sample_second(ss), .i_pair_request(pair_req), .o_sample_taken(taken),
    .o_pairing(pairing), .link(link));
  dac_input_device u_dac_input_device (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .link(link), .o_code_first(code_a),
    .o_code_second(code_b), .o_switch_first(sw_a), .o_switch_second(sw_b),
    .o_update_first(upd_a), .o_update_second(upd_b),
    .o_divided_converter_clock(div_clk), .o_mode_dual(mode_seen));
  dac_link_asserts u_dac_link_asserts (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .data_first(link.data_first),
    .write_strobe_first(link.write_strobe_first),
    .write_strobe_second(link.write_strobe_second),
    .update_clock_first(link.update_clock_first),
    .update_clock_second(link.update_clock_second),
    .channel_select(link.channel_select),
    .pairing_reset(link.pairing_reset), .mode_strap(link.mode_strap));

  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [DW-1:0] word(input int k);
    return DW'((k + 1) * 16'h0a5b);
  endfunction : word

  function automatic logic [SW-1:0] dec(input logic [DW-1:0] c);
    logic [dac_link_pkg::THERMO_WIDTH-1:0] t;
    for (int i = 0; i < dac_link_pkg::THERMO_WIDTH; i++)
      t[i] = (i < int'(c[DW-1:dac_link_pkg::LSB_BITS]));
    return {t, c[dac_link_pkg::LSB_BITS-1:0]};
  endfunction : dec

  // records written words with the update count seen at their write rise
  always @(posedge i_sys_clk) begin
    wa_prev <= link.write_strobe_first;
    wb_prev <= link.write_strobe_second;
    pr <= {pr[2:0], link.pairing_reset};
    if (&pr) check(32'(div_clk), 32'h0);
    if (upd_a) begin
      ua.push_back(code_a);
      check(32'(sw_a), 32'(dec(code_a)));
    end
    if (upd_b) begin
      ub.push_back(code_b);
      check(32'(sw_b), 32'(dec(code_b)));
    end
    if (link.write_strobe_first && !wa_prev) begin
      if (mode_seen || link.channel_select) begin
        wa.push_back(link.data_first);
        pa.push_back(ua.size());
      end else begin
        wb.push_back(link.data_first);
        pb.push_back(ub.size());
      end
    end
    if (mode_seen && link.write_strobe_second && !wb_prev) begin
      wb.push_back(link.data_second);
      pb.push_back(ub.size());
    end
  end

  task automatic do_reset(input logic dual);
    i_rst_n <= 1'b0;
    mode_dual <= dual;
    repeat (4) @(posedge i_sys_clk);
    check(32'(mode_seen), 32'h1);
    check(32'(code_a), 32'h0);
    ua.delete(); ub.delete(); wa.delete(); wb.delete();
    pa.delete(); pb.delete();
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    check(32'(mode_seen), 32'(dual));
  endtask : do_reset

  task automatic send(input int n);
    int w;
    for (int k = 0; k < n; k++) begin
      sf <= word(k);
      ss <= word(k) ^ 14'h3fff;
      valid <= 1'b1;
      w = 0;
      do begin
        @(posedge i_sys_clk);
        w++;
      end while (taken !== 1'b1 && w < 40);
      check(32'(taken), 32'h1);
    end
    valid <= 1'b0;
  endtask : send

  task automatic lat_check(ref logic [DW-1:0] w[$], ref int p[$],
      ref logic [DW-1:0] u[$]);
    int j;
    for (int k = 2; k < w.size(); k++) begin
      j = p[k] + dac_link_pkg::LATENCY_UPDATES;
      if (j < u.size()) check(32'(u[j]), 32'(w[k]));
    end
  endtask : lat_check

  task automatic test_dual();
    int n0;
    do_reset(1'b1);
    send(6);
    repeat (40) @(posedge i_sys_clk);
    check(32'(code_a), 32'(word(5)));
    check(32'(code_b), 32'(word(5) ^ 14'h3fff));
    n0 = ua.size();
    repeat (32) @(posedge i_sys_clk);
    check(32'(ua.size() - n0), 32'h8);
    check(32'(ub.size()), 32'(ua.size()));
    lat_check(wa, pa, ua);
    lat_check(wb, pb, ub);
    $display("test_dual done");
  endtask : test_dual

  task automatic test_interleaved();
    int i;
    int w;
    int n0;
    do_reset(1'b0);
    w = 0;
    while (pairing !== 1'b0 && w < 40) begin
      @(posedge i_sys_clk);
      w++;
    end
    check(32'(pairing), 32'h0);
    pair_req <= 1'b1;
    @(posedge i_sys_clk);
    pair_req <= 1'b0;
    @(posedge i_sys_clk);
    check(32'(pairing), 32'h1);
    repeat (16) @(posedge i_sys_clk);
    send(6);
    repeat (80) @(posedge i_sys_clk);
    n0 = ua.size();
    repeat (32) @(posedge i_sys_clk);
    check(32'(ua.size() - n0), 32'h4);
    check(32'(ub.size()), 32'(ua.size()));
    i = -1;
    foreach (ua[j]) if (i < 0 && ua[j] === word(0)) i = j;
    check(32'(i >= 0), 32'h1);
    for (int k = 0; k < 6; k++) begin
      if (i >= 0 && i + k < ua.size() && i + k < ub.size()) begin
        check(32'(ua[i + k]), 32'(word(k)));
        check(32'(ub[i + k]), 32'(word(k) ^ 14'h3fff));
      end
    end
    $display("test_interleaved done");
  endtask : test_interleaved

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4000) @(posedge i_sys_clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    test_dual();
    test_interleaved();
    report_and_stop();
  end
endmodule : tb_dual_dac_input_interface
